// >>> core/mcr_control_regs.sv
// Measurement control register bank with its serial access port
`timescale 1ns/1ns

// ----------------------------------------
// Register bank top
// ----------------------------------------
//
// Contract
// - Hold 16-bit sample drop count, high byte at 0x0f, low at 0x10.
// - Hold 16-bit monitor current threshold, high byte 0x11, low 0x12.
// - Gain bits 7:6 pick current gain 5/25/40/100; reset code 01.
// - Gain bits 5:4 pick voltage gain, same codes, reset 01; bits 3:0 reserved.
// - Power bit 7 gates the current channel chopper clock.
// - Power bit 6 gates the voltage channel chopper clock; bits 5:4 reserved.
// - Power bit 3 enables the current channel amplifier.
// - Power bit 2 enables the current channel modulator.
// - Power bits 1 and 0 enable voltage amplifier and modulator.
module mcr_control_regs
	import mcr_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	// Serial interface
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        sdi_i,
	output logic             sdo_o,
	output logic             sdo_oe_o,
	// Monitoring mode two settings
	output logic [15:0]      sample_drop_count_o,
	output logic             sample_drop_count_update_o,
	output logic [15:0]      monitor_threshold_o,
	output logic             monitor_threshold_update_o,
	// Amplifier gains
	output logic [1:0]       current_gain_code_o,
	output logic [6:0]       current_gain_factor_o,
	output logic [1:0]       voltage_gain_code_o,
	output logic [6:0]       voltage_gain_factor_o,
	// Channel enables
	output logic             current_chop_clk_en_o,
	output logic             voltage_chop_clk_en_o,
	output logic             current_amp_en_o,
	output logic             current_mod_en_o,
	output logic             voltage_amp_en_o,
	output logic             voltage_mod_en_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [6:0] gain_factor(input logic [1:0] code);
		logic [6:0] f;
		f = GAIN_FACTOR_25;
		case (code)
			GAIN_CODE_5:   f = GAIN_FACTOR_5;
			GAIN_CODE_25:  f = GAIN_FACTOR_25;
			GAIN_CODE_40:  f = GAIN_FACTOR_40;
			GAIN_CODE_100: f = GAIN_FACTOR_100;
			default:       f = GAIN_FACTOR_25;
		endcase
		return f;
	endfunction

	// Writable bits take the new value, reserved bits fall back to reset
	function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask,
		input logic [7:0] rst);
		return (data & mask) | (rst & ~mask);
	endfunction

	// ----------------------------------------
	// Serial access
	// ----------------------------------------
	logic              wr;
	logic              rd;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata;
	logic              rd_valid_reg, rd_valid_next;
	logic [7:0]        rdata_reg, rdata_next;

	mcr_serial_slave u_serial (
		.core_clk_i (core_clk_i),
		.arst_n_i   (arst_n_i),
		.sclk_i     (sclk_i),
		.cs_n_i     (cs_n_i),
		.sdi_i      (sdi_i),
		.sdo_o      (sdo_o),
		.sdo_oe_o   (sdo_oe_o),
		.wr_o       (wr),
		.rd_o       (rd),
		.addr_o     (addr),
		.wdata_o    (wdata),
		.rd_valid_i (rd_valid_reg),
		.rdata_i    (rdata_reg)
	);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] drop_high_reg, drop_high_next;
	logic [7:0] drop_low_reg, drop_low_next;
	logic [7:0] thresh_high_reg, thresh_high_next;
	logic [7:0] thresh_low_reg, thresh_low_next;
	logic [7:0] gain_reg, gain_next;
	logic [7:0] power_reg, power_next;
	logic       drop_upd_reg, drop_upd_next;
	logic       thresh_upd_reg, thresh_upd_next;

	always_comb begin
		drop_high_next   = drop_high_reg;
		drop_low_next    = drop_low_reg;
		thresh_high_next = thresh_high_reg;
		thresh_low_next  = thresh_low_reg;
		gain_next        = gain_reg;
		power_next       = power_reg;
		drop_upd_next    = 1'b0;
		thresh_upd_next  = 1'b0;
		if (wr) begin
			case (addr)
				ADDR_DROP_HIGH: begin
					drop_high_next = wdata;
				end
				ADDR_DROP_LOW: begin
					drop_low_next = wdata;
					// Low byte completes the word
					drop_upd_next = 1'b1;
				end
				ADDR_THRESH_HIGH: begin
					thresh_high_next = wdata;
				end
				ADDR_THRESH_LOW: begin
					thresh_low_next = wdata;
					thresh_upd_next = 1'b1;
				end
				ADDR_GAIN_SELECT: begin
					gain_next = masked(wdata, MASK_GAIN_SELECT, RST_GAIN_SELECT);
				end
				ADDR_POWER_ENABLES: begin
					power_next = masked(wdata, MASK_POWER_ENABLES, RST_POWER_ENABLES);
				end
				default: begin
					// Writes to unmapped addresses are dropped
					drop_upd_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			drop_high_reg   <= RST_DROP_HIGH;
			drop_low_reg    <= RST_DROP_LOW;
			thresh_high_reg <= RST_THRESH_HIGH;
			thresh_low_reg  <= RST_THRESH_LOW;
			gain_reg        <= RST_GAIN_SELECT;
			power_reg       <= RST_POWER_ENABLES;
			drop_upd_reg    <= 1'b0;
			thresh_upd_reg  <= 1'b0;
		end else begin
			drop_high_reg   <= drop_high_next;
			drop_low_reg    <= drop_low_next;
			thresh_high_reg <= thresh_high_next;
			thresh_low_reg  <= thresh_low_next;
			gain_reg        <= gain_next;
			power_reg       <= power_next;
			drop_upd_reg    <= drop_upd_next;
			thresh_upd_reg  <= thresh_upd_next;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		rd_valid_next = rd;
		rdata_next    = rdata_reg;
		if (rd) begin
			case (addr)
				ADDR_DROP_HIGH:     rdata_next = drop_high_reg;
				ADDR_DROP_LOW:      rdata_next = drop_low_reg;
				ADDR_THRESH_HIGH:   rdata_next = thresh_high_reg;
				ADDR_THRESH_LOW:    rdata_next = thresh_low_reg;
				ADDR_GAIN_SELECT:   rdata_next = gain_reg;
				ADDR_POWER_ENABLES: rdata_next = power_reg;
				default:            rdata_next = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_valid_reg <= 1'b0;
			rdata_reg    <= 8'h00;
		end else begin
			rd_valid_reg <= rd_valid_next;
			rdata_reg    <= rdata_next;
		end
	end

	// ----------------------------------------
	// Decoded gain factors
	// ----------------------------------------
	// Tracked from the next value so factor and code change on the same edge
	logic [6:0] cur_factor_reg, cur_factor_next;
	logic [6:0] volt_factor_reg, volt_factor_next;

	always_comb begin
		cur_factor_next  = gain_factor(gain_next[GAIN_CUR_LSB +: 2]);
		volt_factor_next = gain_factor(gain_next[GAIN_VOLT_LSB +: 2]);
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cur_factor_reg  <= GAIN_FACTOR_25;
			volt_factor_reg <= GAIN_FACTOR_25;
		end else begin
			cur_factor_reg  <= cur_factor_next;
			volt_factor_reg <= volt_factor_next;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flops
	// ----------------------------------------
	assign sample_drop_count_o        = {drop_high_reg, drop_low_reg};
	assign sample_drop_count_update_o = drop_upd_reg;
	assign monitor_threshold_o        = {thresh_high_reg, thresh_low_reg};
	assign monitor_threshold_update_o = thresh_upd_reg;
	assign current_gain_code_o        = gain_reg[GAIN_CUR_LSB +: 2];
	assign current_gain_factor_o      = cur_factor_reg;
	assign voltage_gain_code_o        = gain_reg[GAIN_VOLT_LSB +: 2];
	assign voltage_gain_factor_o      = volt_factor_reg;
	assign current_chop_clk_en_o      = power_reg[PWR_CUR_CHOP];
	assign voltage_chop_clk_en_o      = power_reg[PWR_VOLT_CHOP];
	assign current_amp_en_o           = power_reg[PWR_CUR_AMP];
	assign current_mod_en_o           = power_reg[PWR_CUR_MOD];
	assign voltage_amp_en_o           = power_reg[PWR_VOLT_AMP];
	assign voltage_mod_en_o           = power_reg[PWR_VOLT_MOD];

endmodule

// >>> shared/mcr_pkg.sv
// Shared constants for the measurement control register bank
package mcr_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam int          ADDR_W               = 7;
	localparam logic [6:0]  ADDR_DROP_HIGH       = 7'h0f;
	localparam logic [6:0]  ADDR_DROP_LOW        = 7'h10;
	localparam logic [6:0]  ADDR_THRESH_HIGH     = 7'h11;
	localparam logic [6:0]  ADDR_THRESH_LOW      = 7'h12;
	localparam logic [6:0]  ADDR_GAIN_SELECT     = 7'h13;
	localparam logic [6:0]  ADDR_POWER_ENABLES   = 7'h14;

	// ----------------------------------------
	// Reset values and writable-bit masks
	// ----------------------------------------
	localparam logic [7:0]  RST_DROP_HIGH        = 8'h00;
	localparam logic [7:0]  RST_DROP_LOW         = 8'h00;
	localparam logic [7:0]  RST_THRESH_HIGH      = 8'h00;
	localparam logic [7:0]  RST_THRESH_LOW       = 8'h00;
	localparam logic [7:0]  RST_GAIN_SELECT      = 8'h50;
	localparam logic [7:0]  RST_POWER_ENABLES    = 8'hcf;
	localparam logic [7:0]  MASK_GAIN_SELECT     = 8'hf0;
	localparam logic [7:0]  MASK_POWER_ENABLES   = 8'hcf;
	localparam logic [7:0]  UNMAPPED_READ        = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int          GAIN_CUR_LSB         = 6;
	localparam int          GAIN_VOLT_LSB        = 4;
	localparam int          PWR_CUR_CHOP         = 7;
	localparam int          PWR_VOLT_CHOP        = 6;
	localparam int          PWR_CUR_AMP          = 3;
	localparam int          PWR_CUR_MOD          = 2;
	localparam int          PWR_VOLT_AMP         = 1;
	localparam int          PWR_VOLT_MOD         = 0;

	// ----------------------------------------
	// Gain codes and factors
	// ----------------------------------------
	localparam logic [1:0]  GAIN_CODE_5          = 2'h0;
	localparam logic [1:0]  GAIN_CODE_25         = 2'h1;
	localparam logic [1:0]  GAIN_CODE_40         = 2'h2;
	localparam logic [1:0]  GAIN_CODE_100        = 2'h3;
	localparam logic [6:0]  GAIN_FACTOR_5        = 7'h05;
	localparam logic [6:0]  GAIN_FACTOR_25       = 7'h19;
	localparam logic [6:0]  GAIN_FACTOR_40       = 7'h28;
	localparam logic [6:0]  GAIN_FACTOR_100      = 7'h64;

	// ----------------------------------------
	// Serial frame layout
	// ----------------------------------------
	localparam logic [3:0]  LAST_CMD_BIT         = 4'h7;
	localparam logic [3:0]  LAST_FRAME_BIT       = 4'hf;

	typedef enum logic [1:0] {
		SER_IDLE,
		SER_CMD,
		SER_DATA,
		SER_DONE
	} mcr_ser_state_t;

endpackage

// >>> core/mcr_serial_slave.sv
// Four-wire serial slave that turns frames into register read and write strobes
`timescale 1ns/1ns
module mcr_serial_slave
	import mcr_pkg::*;
(
	// Clock and reset
	input  wire logic              core_clk_i,
	input  wire logic              arst_n_i,
	// Serial pins
	input  wire logic              sclk_i,
	input  wire logic              cs_n_i,
	input  wire logic              sdi_i,
	output logic                   sdo_o,
	output logic                   sdo_oe_o,
	// Register side
	output logic                   wr_o,
	output logic                   rd_o,
	output logic [ADDR_W-1:0]      addr_o,
	output logic [7:0]             wdata_o,
	input  wire logic              rd_valid_i,
	input  wire logic [7:0]        rdata_i
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] sclk_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       selected;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg   <= 2'h3;
			sdi_sync_reg  <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_i};
			cs_sync_reg   <= {cs_sync_reg[0], cs_n_i};
			sdi_sync_reg  <= {sdi_sync_reg[0], sdi_i};
		end
	end

	// Edges use stages two and three only
	assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
	assign selected  = ~cs_sync_reg[1];

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	mcr_ser_state_t    state_reg, state_next;
	logic [3:0]        cnt_reg, cnt_next;
	logic [6:0]        shift_reg, shift_next;
	logic [7:0]        tx_reg, tx_next;
	logic              rnw_reg, rnw_next;
	logic              sdo_reg, sdo_next;
	logic              oe_reg, oe_next;
	logic              wr_reg, wr_next;
	logic              rd_reg, rd_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [7:0]        wdata_reg, wdata_next;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		tx_next    = tx_reg;
		rnw_next   = rnw_reg;
		sdo_next   = sdo_reg;
		oe_next    = selected;
		wr_next    = 1'b0;
		rd_next    = 1'b0;
		addr_next  = addr_reg;
		wdata_next = wdata_reg;
		if (rd_valid_i) begin
			tx_next = rdata_i;
		end
		if (!selected) begin
			state_next = SER_IDLE;
			sdo_next   = 1'b0;
		end else begin
			case (state_reg)
				SER_IDLE: begin
					state_next = SER_CMD;
					cnt_next   = 4'h0;
					sdo_next   = 1'b0;
				end
				SER_CMD: begin
					if (sclk_rise) begin
						shift_next = {shift_reg[5:0], sdi_sync_reg[1]};
						cnt_next   = cnt_reg + 4'h1;
						if (cnt_reg == LAST_CMD_BIT) begin
							rnw_next   = shift_reg[6];
							addr_next  = {shift_reg[5:0], sdi_sync_reg[1]};
							rd_next    = shift_reg[6];
							state_next = SER_DATA;
						end
					end
				end
				SER_DATA: begin
					if (sclk_fall) begin
						sdo_next = rnw_reg & tx_reg[7];
						tx_next  = {tx_reg[6:0], 1'b0};
					end
					if (sclk_rise) begin
						shift_next = {shift_reg[5:0], sdi_sync_reg[1]};
						cnt_next   = cnt_reg + 4'h1;
						if (cnt_reg == LAST_FRAME_BIT) begin
							wr_next    = ~rnw_reg;
							wdata_next = {shift_reg, sdi_sync_reg[1]};
							state_next = SER_DONE;
						end
					end
				end
				SER_DONE: begin
					// Extra clocks until deselect are ignored
					if (sclk_fall) begin
						sdo_next = 1'b0;
					end
				end
				default: begin
					state_next = SER_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= SER_IDLE;
			cnt_reg   <= 4'h0;
			shift_reg <= 7'h00;
			tx_reg    <= 8'h00;
			rnw_reg   <= 1'b0;
			sdo_reg   <= 1'b0;
			oe_reg    <= 1'b0;
			wr_reg    <= 1'b0;
			rd_reg    <= 1'b0;
			addr_reg  <= 7'h00;
			wdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
			tx_reg    <= tx_next;
			rnw_reg   <= rnw_next;
			sdo_reg   <= sdo_next;
			oe_reg    <= oe_next;
			wr_reg    <= wr_next;
			rd_reg    <= rd_next;
			addr_reg  <= addr_next;
			wdata_reg <= wdata_next;
		end
	end

	assign sdo_o    = sdo_reg;
	assign sdo_oe_o = oe_reg;
	assign wr_o     = wr_reg;
	assign rd_o     = rd_reg;
	assign addr_o   = addr_reg;
	assign wdata_o  = wdata_reg;

endmodule

// >>> verif/mcr_control_regs_asserts.sv
// Port checker for the measurement control register bank
`timescale 1ns/1ns
module mcr_control_regs_asserts (
	// Clock, reset and serial pins
	input wire logic        core_clk_i,
	input wire logic        arst_n_i,
	input wire logic        sclk_i,
	input wire logic        cs_n_i,
	input wire logic        sdi_i,
	input wire logic        sdo_o,
	input wire logic        sdo_oe_o,
	// Register outputs
	input wire logic [15:0] sample_drop_count_o,
	input wire logic        sample_drop_count_update_o,
	input wire logic [15:0] monitor_threshold_o,
	input wire logic        monitor_threshold_update_o,
	input wire logic [1:0]  current_gain_code_o,
	input wire logic [6:0]  current_gain_factor_o,
	input wire logic [1:0]  voltage_gain_code_o,
	input wire logic [6:0]  voltage_gain_factor_o,
	input wire logic        current_chop_clk_en_o,
	input wire logic        voltage_chop_clk_en_o,
	input wire logic        current_amp_en_o,
	input wire logic        current_mod_en_o,
	input wire logic        voltage_amp_en_o,
	input wire logic        voltage_mod_en_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_cur_gain_map: assert property (current_gain_factor_o == (current_gain_code_o == 2'h0 ? 7'h05 :
		current_gain_code_o == 2'h1 ? 7'h19 : current_gain_code_o == 2'h2 ? 7'h28 : 7'h64))
		else $error("current gain factor does not match code");
	a_volt_gain_map: assert property (voltage_gain_factor_o == (voltage_gain_code_o == 2'h0 ? 7'h05 :
		voltage_gain_code_o == 2'h1 ? 7'h19 : voltage_gain_code_o == 2'h2 ? 7'h28 : 7'h64))
		else $error("voltage gain factor does not match code");
	a_drop_low_pulse: assert property ($changed(sample_drop_count_o[7:0]) |-> sample_drop_count_update_o)
		else $error("drop count low byte changed without pulse");
	a_thresh_low_pulse: assert property ($changed(monitor_threshold_o[7:0]) |-> monitor_threshold_update_o)
		else $error("threshold low byte changed without pulse");
	a_pulse_one_cycle: assert property ((sample_drop_count_update_o || monitor_threshold_update_o) |=>
		!(sample_drop_count_update_o || monitor_threshold_update_o))
		else $error("update pulse longer than one cycle");
	a_reset_values: assert property ($rose(arst_n_i) |-> current_gain_code_o == 2'h1 &&
		voltage_gain_code_o == 2'h1 && sample_drop_count_o == 16'h0000 && monitor_threshold_o == 16'h0000 &&
		{current_chop_clk_en_o, voltage_chop_clk_en_o, current_amp_en_o, current_mod_en_o} == 4'hf)
		else $error("wrong values after reset");
	// Writes land within a few clocks of the last bit, so a long deselect means no change
	a_idle_settings: assert property (cs_n_i [*8] |-> $stable({current_gain_code_o, voltage_gain_code_o,
		current_chop_clk_en_o, voltage_chop_clk_en_o, current_amp_en_o, current_mod_en_o,
		voltage_amp_en_o, voltage_mod_en_o})) else $error("settings changed while deselected");
	a_idle_counts: assert property (cs_n_i [*8] |-> $stable({sample_drop_count_o, monitor_threshold_o}) &&
		!sample_drop_count_update_o && !monitor_threshold_update_o) else $error("counts moved while deselected");
endmodule

bind mcr_control_regs mcr_control_regs_asserts u_mcr_control_regs_asserts (.*);

// >>> verif/mcr_host_model.sv
// Serial master model standing in for the microcontroller
`timescale 1ns/1ns
module mcr_host_model #(
	parameter int HALF = 5
) (
	input  wire logic core_clk_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o  = 1'b0;
	end

	// Sends the top nbits of a frame; fewer than 16 cuts the frame short
	task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
		int i;
		rd = 8'h00;
		@(negedge core_clk_i) cs_n_o = 1'b0;
		for (i = 15; i > 15 - nbits; i--) begin
			repeat (HALF) @(negedge core_clk_i);
			sdi_o = frame[i];
			if (i < 8)
				rd[i] = sdo_i;
			repeat (HALF) @(negedge core_clk_i);
			sclk_o = 1'b1;
			repeat (HALF) @(negedge core_clk_i);
			sclk_o = 1'b0;
		end
		repeat (6) @(negedge core_clk_i);
		cs_n_o = 1'b1;
		// Released line must not keep looking like valid data
		sdi_o = ~sdi_o;
		repeat (6) @(negedge core_clk_i);
	endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the measurement control register bank
`timescale 1ns/1ns
module testbench;
	typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] r;} mcr_row_t;
	logic        core_clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o;
	logic [15:0] sample_drop_count_o, monitor_threshold_o;
	logic        sample_drop_count_update_o, monitor_threshold_update_o;
	logic [1:0]  current_gain_code_o, voltage_gain_code_o;
	logic [6:0]  current_gain_factor_o, voltage_gain_factor_o;
	logic        current_chop_clk_en_o, voltage_chop_clk_en_o, current_amp_en_o;
	logic        current_mod_en_o, voltage_amp_en_o, voltage_mod_en_o;
	logic [7:0]  sh [0:127];
	logic [7:0]  rd;
	logic [15:0] npulse = 16'h0000;
	logic [15:0] np;
	logic [15:0] n_oe = 16'h0000;
	logic [15:0] noe;
	logic [6:0]  gtab [4] = '{7'h05, 7'h19, 7'h28, 7'h64};
	int          n_mismatch = 0;
	int          checks = 0;
	int          cyc = 0;
	mcr_row_t    rows [14] = '{'{7'h0f, 8'ha5, 8'ha5}, '{7'h10, 8'h3c, 8'h3c}, '{7'h11, 8'hff, 8'hff},
		'{7'h12, 8'h01, 8'h01}, '{7'h13, 8'h0f, 8'h00}, '{7'h13, 8'h5a, 8'h50}, '{7'h13, 8'ha0, 8'ha0},
		'{7'h13, 8'hf5, 8'hf0}, '{7'h14, 8'h30, 8'h00}, '{7'h14, 8'h8a, 8'h8a}, '{7'h14, 8'h45, 8'h45},
		'{7'h14, 8'hff, 8'hcf}, '{7'h15, 8'h77, 8'h00}, '{7'h0e, 8'h12, 8'h00}};

	mcr_control_regs u_mcr_control_regs (.*);
	mcr_host_model u_mcr_host_model (.core_clk_i(core_clk_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
		.sdi_o(sdi_i), .sdo_i(sdo_o));

	always #10 core_clk_i = ~core_clk_i;

	always @(posedge core_clk_i) begin
		cyc++;
		if (sample_drop_count_update_o === 1'b1 || monitor_threshold_update_o === 1'b1)
			npulse++;
		if (sdo_oe_o === 1'b1)
			n_oe++;
		// About 31 frames of about 260 clocks each
		if (cyc == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic clear_shadow();
		foreach (sh[i])
			sh[i] = 8'h00;
		sh[8'h13] = 8'h50;
		sh[8'h14] = 8'hcf;
	endtask

	task automatic outs();
		chk("drop", {sh[8'h0f], sh[8'h10]}, sample_drop_count_o);
		chk("thresh", {sh[8'h11], sh[8'h12]}, monitor_threshold_o);
		chk("cgain", {7'h0, gtab[sh[8'h13][7:6]], sh[8'h13][7:6]},
			{7'h0, current_gain_factor_o, current_gain_code_o});
		chk("vgain", {7'h0, gtab[sh[8'h13][5:4]], sh[8'h13][5:4]},
			{7'h0, voltage_gain_factor_o, voltage_gain_code_o});
		chk("chop", {14'h0, sh[8'h14][7:6]}, {14'h0, current_chop_clk_en_o, voltage_chop_clk_en_o});
		chk("cur_amp", {15'h0, sh[8'h14][3]}, {15'h0, current_amp_en_o});
		chk("cur_mod", {15'h0, sh[8'h14][2]}, {15'h0, current_mod_en_o});
		chk("volt_en", {14'h0, sh[8'h14][1:0]}, {14'h0, voltage_amp_en_o, voltage_mod_en_o});
		// Bench only calls this between frames, so the pin must be released
		chk("oe_idle", 16'h0000, {15'h0, sdo_oe_o});
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		clear_shadow();
		repeat (4) @(posedge core_clk_i);
		@(negedge core_clk_i) arst_n_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		outs();
		$display("reset test done");
		foreach (rows[i]) begin
			np = npulse;
			noe = n_oe;
			u_mcr_host_model.xfer({1'b0, rows[i].a, rows[i].d}, 16, rd);
			chk("pulse", {15'h0, rows[i].a == 7'h10 || rows[i].a == 7'h12}, npulse - np);
			// Select is low for 16 bits of three half periods plus a six-clock tail
			chk("oe_count", 16'h00f6, n_oe - noe);
			if (rows[i].a inside {[7'h0f:7'h14]})
				sh[rows[i].a] = rows[i].r;
			u_mcr_host_model.xfer({1'b1, rows[i].a, 8'h00}, 16, rd);
			chk("rdata", {8'h0, rows[i].r}, {8'h0, rd});
			outs();
			$display("row %0d done", i);
		end
		// Frame cut short after 12 bits must leave the gain register alone
		u_mcr_host_model.xfer({1'b0, 7'h13, 8'h00}, 12, rd);
		outs();
		$display("aborted frame test done");
		@(negedge core_clk_i) arst_n_i = 1'b0;
		repeat (4) @(negedge core_clk_i);
		arst_n_i = 1'b1;
		clear_shadow();
		repeat (4) @(negedge core_clk_i);
		outs();
		u_mcr_host_model.xfer({1'b1, 7'h14, 8'h00}, 16, rd);
		chk("rdata", 16'h00cf, {8'h0, rd});
		u_mcr_host_model.xfer({1'b1, 7'h13, 8'h00}, 16, rd);
		chk("rdata", 16'h0050, {8'h0, rd});
		$display("second reset test done");
		report_and_stop();
	end
endmodule
